// [hw/ntc_pkg.sv]
// Purpose: Shared constants and types for the NAND chain connectivity test
// Assumes: One 40 MHz clock on both ends of the test link
// Notes:   Chain positions are counted from 1; bit k-1 carries position k

package ntc_pkg;

    // Chain geometry
    localparam int NTC_CHAIN_INPUTS    = 49;
    localparam int NTC_OUTPUT_POSITION = 50;
    localparam int NTC_IDX_W           = 6;
    localparam int NTC_CNT_W           = 7;

    // Strap code that selects the chain test at reset release
    localparam int          NTC_STRAP_W         = 3;
    localparam logic [2:0]  NTC_STRAP_TEST_CODE = 3'h5;
    localparam logic [2:0]  NTC_STRAP_IDLE_CODE = 3'h0;

    // Idle level of the result pin and of the chain inputs
    localparam logic        NTC_PIN_HIGH        = 1'b1;
    localparam logic        NTC_PIN_LOW         = 1'b0;

    // Clock and settle time between a step and its check
    localparam int NTC_CLK_FREQ_MHZ   = 40;
    localparam int NTC_SETTLE_TIME_NS = 100;
    localparam int NTC_SETTLE_RAW     =
        (NTC_SETTLE_TIME_NS * NTC_CLK_FREQ_MHZ + 999) / 1000;
    localparam int NTC_SETTLE_CYCLES  =
        (NTC_SETTLE_RAW < 1) ? 1 : NTC_SETTLE_RAW;
    localparam int NTC_TIMER_W        = 8;

    // Result pin is registered once inside the device end
    localparam int NTC_DEVICE_LATENCY = 1;

    typedef enum {
        NTC_S_IDLE,
        NTC_S_RAISE,
        NTC_S_CHECK_HIGH,
        NTC_S_LOWER,
        NTC_S_WAIT,
        NTC_S_CHECK
    } ntc_state_t;

endpackage : ntc_pkg

// [hw/ntc_if.sv]
// Purpose: Pin bundle between the switch device end and the board tester
// Assumes: Result pin has a board pull-up when nobody drives it
// Notes:   chain_result_pin is the resolved wire level seen by the board

`timescale 1ns/1ps

interface ntc_if
    import ntc_pkg::*;
#(
    parameter int N = NTC_CHAIN_INPUTS
);
    logic [N-1:0] chain_in;
    logic         test_strap_a;
    logic         test_strap_b;
    logic         test_strap_c;
    logic         chain_result_out;
    logic         chain_result_oe;
    wire          chain_result_pin;

    // Undriven pin floats high through the pull-up
    assign chain_result_pin = chain_result_oe ? chain_result_out
                                              : NTC_PIN_HIGH;

    modport device (
        input  chain_in,
        input  test_strap_a,
        input  test_strap_b,
        input  test_strap_c,
        output chain_result_out,
        output chain_result_oe
    );

    modport board (
        output chain_in,
        output test_strap_a,
        output test_strap_b,
        output test_strap_c,
        input  chain_result_pin
    );

endinterface : ntc_if

// [hw/ntc_device_end.sv]
// Purpose: Device side of the NAND chain connectivity test
// Assumes: Straps are stable around the release of RESET
// Notes:   Outside test mode the result pin is an open-drain interrupt

`timescale 1ns/1ps

module ntc_device_end
    import ntc_pkg::*;
#(
    parameter int N = NTC_CHAIN_INPUTS
)
(
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic INT_REQ,
    output logic      TEST_MODE,
    ntc_if.device     LINK
);
    import ntc_pkg::*;

    localparam logic ODD_LENGTH = ((N % 2) == 1);

    logic                   strap_taken;
    logic                   test_mode;
    logic                   chain_q;
    logic                   chain_level;
    logic [NTC_STRAP_W-1:0] strap_bus;
    logic [N:0]             stage;

    generate
        if (N < 2 || N >= (1 << NTC_IDX_W))
        begin : g_bad_length
            $error("ntc_device_end: chain length out of range");
        end
    endgenerate

    assign strap_bus = {LINK.test_strap_a, LINK.test_strap_b,
                        LINK.test_strap_c};

    // Straps are caught once, on the first edge after reset release
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            strap_taken <= 1'b0;
            test_mode   <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            test_mode   <= (strap_bus == NTC_STRAP_TEST_CODE);
        end
    end

    // Each input feeds one gate; position 1 sits deepest in the chain
    assign stage[0] = NTC_PIN_HIGH;
    generate
        for (genvar k = 0; k < N; k++)
        begin : g_chain
            assign stage[k+1] = ~(LINK.chain_in[k] & stage[k]);
        end
    endgenerate

    // Last gate inverts for an odd length so all-high reads high
    assign chain_level = ODD_LENGTH ? ~stage[N] : stage[N];

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            chain_q <= NTC_PIN_HIGH;
        else
            chain_q <= chain_level;
    end

    // Test mode drives the pin both ways; otherwise pull low on interrupt
    assign LINK.chain_result_out = test_mode ? chain_q : NTC_PIN_LOW;
    assign LINK.chain_result_oe  = test_mode | INT_REQ;
    assign TEST_MODE             = test_mode;

endmodule : ntc_device_end

// [hw/ntc_board_end.sv]
// Purpose: Board test logic that walks the NAND chain and flags faults
// Assumes: ENABLE is steady around the device's reset release
// Notes:   One START runs the whole walk; results hold until next START
//
// Notes on behaviour
// - Test straps select chain mode at reset
// - All inputs high gives high result first
// - Walk positions 1 to 49; output is 50
// - Lowering first input drops result low
// - Then lowering second input raises result
// - Keep earlier inputs low; lower all inputs
// - No toggle after lowering marks input faulty
// - Every input feeds one gate of chain

`timescale 1ns/1ps

module ntc_board_end
    import ntc_pkg::*;
#(
    parameter int N             = NTC_CHAIN_INPUTS,
    parameter int SETTLE_CYCLES = NTC_SETTLE_CYCLES
)
(
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 ENABLE,
    input  wire logic                 START,
    output logic                      BUSY,
    output logic                      DONE,
    output logic                      PASS,
    output logic                      INIT_FAIL,
    output logic                      LEVEL_ERROR,
    output logic [NTC_CNT_W-1:0]      FAULT_COUNT,
    output logic [NTC_IDX_W-1:0]      FIRST_FAULT,
    output logic [N-1:0]              FAULT_MAP,
    output logic [NTC_IDX_W-1:0]      STEP,
    ntc_if.board                      LINK
);
    import ntc_pkg::*;

    localparam logic [NTC_IDX_W-1:0]   LAST_IDX   = NTC_IDX_W'(N - 1);
    localparam logic [NTC_TIMER_W-1:0] SETTLE_VAL =
        NTC_TIMER_W'(SETTLE_CYCLES);
    localparam logic [NTC_IDX_W-1:0]   NO_FAULT   = '0;

    ntc_state_t                state;
    ntc_state_t                next_state;
    logic [N-1:0]              low_mask;
    logic [NTC_IDX_W-1:0]      idx;
    logic [NTC_TIMER_W-1:0]    timer;
    logic                      prev_level;
    logic                      done;
    logic                      pass;
    logic                      init_fail;
    logic                      level_error;
    logic [NTC_CNT_W-1:0]      fault_count;
    logic [NTC_IDX_W-1:0]      first_fault;
    logic [N-1:0]              fault_map;
    logic [NTC_IDX_W-1:0]      step;

    logic                      start_ok;
    logic                      timer_zero;
    logic                      sample;
    logic                      toggled;
    logic                      expected_level;
    logic                      last_step;
    logic [NTC_STRAP_W-1:0]    strap_drive;
    logic [NTC_IDX_W-1:0]      position;

    generate
        if (N < 2 || N >= (1 << NTC_IDX_W))
        begin : g_bad_length
            $error("ntc_board_end: chain length out of range");
        end
        if (SETTLE_CYCLES <= NTC_DEVICE_LATENCY ||
            SETTLE_CYCLES >= (1 << NTC_TIMER_W))
        begin : g_bad_settle
            $error("ntc_board_end: settle count out of range");
        end
    endgenerate

    // Static straps; the device catches them at its reset release
    assign strap_drive = ENABLE ? NTC_STRAP_TEST_CODE
                                : NTC_STRAP_IDLE_CODE;
    assign LINK.test_strap_a = strap_drive[2];
    assign LINK.test_strap_b = strap_drive[1];
    assign LINK.test_strap_c = strap_drive[0];

    // Lowered inputs stay low until the next walk starts
    assign LINK.chain_in = ~low_mask;

    assign sample         = LINK.chain_result_pin;
    assign start_ok       = START & ENABLE;
    assign timer_zero     = (timer == '0);
    assign toggled        = (sample != prev_level);
    assign last_step      = (idx == LAST_IDX);
    assign position       = idx + NTC_IDX_W'(1);
    // After idx+1 inputs are low, odd count means low result
    assign expected_level = idx[0];

    always_comb
    begin
        next_state = state;
        case (state)
            NTC_S_IDLE:
                if (start_ok)
                    next_state = NTC_S_RAISE;
            NTC_S_RAISE:
                if (timer_zero)
                    next_state = NTC_S_CHECK_HIGH;
            NTC_S_CHECK_HIGH:
                next_state = NTC_S_LOWER;
            NTC_S_LOWER:
                next_state = NTC_S_WAIT;
            NTC_S_WAIT:
                if (timer_zero)
                    next_state = NTC_S_CHECK;
            NTC_S_CHECK:
                next_state = last_step ? NTC_S_IDLE : NTC_S_LOWER;
            default:
                next_state = NTC_S_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            state <= NTC_S_IDLE;
        else
            state <= next_state;
    end

    // Drive pattern, step index and settle timer
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            low_mask <= '0;
            idx      <= '0;
            timer    <= '0;
        end
        else if (state == NTC_S_IDLE && start_ok)
        begin
            low_mask <= '0;
            idx      <= '0;
            timer    <= SETTLE_VAL;
        end
        else if (state == NTC_S_LOWER)
        begin
            low_mask[idx] <= 1'b1;
            timer         <= SETTLE_VAL;
        end
        else if (state == NTC_S_CHECK && !last_step)
            idx <= position;
        else if (!timer_zero)
            timer <= timer - NTC_TIMER_W'(1);
    end

    // Level seen at the previous check, for toggle detection
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            prev_level <= NTC_PIN_HIGH;
        else if (state == NTC_S_CHECK_HIGH || state == NTC_S_CHECK)
            prev_level <= sample;
    end

    // Initial all-high check
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            init_fail <= 1'b0;
        else if (state == NTC_S_IDLE && start_ok)
            init_fail <= 1'b0;
        else if (state == NTC_S_CHECK_HIGH)
            init_fail <= (sample != NTC_PIN_HIGH);
    end

    // Per-step fault record
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            fault_map   <= '0;
            fault_count <= '0;
            first_fault <= NO_FAULT;
            level_error <= 1'b0;
        end
        else if (state == NTC_S_IDLE && start_ok)
        begin
            fault_map   <= '0;
            fault_count <= '0;
            first_fault <= NO_FAULT;
            level_error <= 1'b0;
        end
        else if (state == NTC_S_CHECK)
        begin
            if (!toggled)
            begin
                fault_map[idx] <= 1'b1;
                fault_count    <= fault_count + NTC_CNT_W'(1);
                if (first_fault == NO_FAULT)
                    first_fault <= position;
            end
            if (sample != expected_level)
                level_error <= 1'b1;
        end
    end

    // Completion and verdict
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            done <= 1'b0;
            pass <= 1'b0;
            step <= '0;
        end
        else
        begin
            done <= (state == NTC_S_CHECK) && last_step;
            if (state == NTC_S_IDLE && start_ok)
            begin
                pass <= 1'b0;
                step <= '0;
            end
            else if (state == NTC_S_CHECK)
            begin
                step <= position;
                if (last_step)
                    pass <= toggled && !init_fail &&
                            (fault_count == '0) && !level_error &&
                            (sample == expected_level);
            end
        end
    end

    assign BUSY        = (state != NTC_S_IDLE);
    assign DONE        = done;
    assign PASS        = pass;
    assign INIT_FAIL   = init_fail;
    assign LEVEL_ERROR = level_error;
    assign FAULT_COUNT = fault_count;
    assign FIRST_FAULT = first_fault;
    assign FAULT_MAP   = fault_map;
    assign STEP        = step;

endmodule : ntc_board_end

// [testbench/ntc_link_properties.sv]
// Purpose: Assertions on the pins between device end and board tester
// Assumes: One clock; RESET asynchronous, active high
// Notes:   Device checks apply only while the test strap code is driven

`timescale 1ns/1ps

module ntc_link_properties
    import ntc_pkg::*;
#(
    parameter int N = NTC_CHAIN_INPUTS
)
(
    input wire logic         CLK,
    input wire logic         RESET,
    input wire logic [N-1:0] chain_in,
    input wire logic         test_strap_a,
    input wire logic         test_strap_b,
    input wire logic         test_strap_c,
    input wire logic         chain_result_out,
    input wire logic         chain_result_oe,
    input wire logic         chain_result_pin
);
    wire logic [2:0]           strap   = {test_strap_a, test_strap_b,
                                          test_strap_c};
    wire logic                 sel     = (strap == NTC_STRAP_TEST_CODE);
    wire logic [N-1:0]         ones    = {N{1'b1}};
    wire logic [NTC_CNT_W-1:0] low_cnt = NTC_CNT_W'($countones(~chain_in));
    // Inputs lowered in order from position 1 upward
    wire logic                 prefix  = (chain_in == (ones << low_cnt));

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_strap_legal;
        strap == NTC_STRAP_TEST_CODE || strap == NTC_STRAP_IDLE_CODE;
    endproperty
    a_strap_legal: assert property (p_strap_legal)
        else $error("strap code is neither test nor idle");

    property p_all_high;
        sel && chain_in == ones |=> chain_result_pin;
    endproperty
    a_all_high: assert property (p_all_high)
        else $error("result low with all inputs high");

    property p_first_fall;
        sel && chain_in == (ones << 1) |=> !chain_result_pin;
    endproperty
    a_first_fall: assert property (p_first_fall)
        else $error("result high after first input lowered");

    property p_second_rise;
        sel && chain_in == (ones << 2) |=> chain_result_pin;
    endproperty
    a_second_rise: assert property (p_second_rise)
        else $error("result low after second input lowered");

    property p_parity;
        sel && prefix |=> chain_result_pin != $past(low_cnt[0]);
    endproperty
    a_parity: assert property (p_parity)
        else $error("result level differs from chain parity");

    property p_hold;
        sel && $stable(chain_in) |=> $stable(chain_result_pin);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result moved with inputs steady");

    property p_one_step;
        $changed(chain_in) && chain_in != ones
            |-> chain_in == ($past(chain_in) << 1);
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("inputs not lowered one at a time in order");

    property p_finish;
        chain_in == (ones << (N - 1)) |-> ##[1:20] chain_in == '0;
    endproperty
    a_finish: assert property (p_finish)
        else $error("last input not lowered in time");

    property p_drive;
        sel |=> chain_result_oe && chain_result_pin == chain_result_out;
    endproperty
    a_drive: assert property (p_drive)
        else $error("result pin not driven in test mode");

    c_walk_start: cover property (sel && chain_in == (ones << 1));
    c_walk_end:   cover property (sel && chain_in == '0);
    c_pin_fall:   cover property (sel && $fell(chain_result_pin));

endmodule : ntc_link_properties

// [testbench/test_nand_tree_connectivity_test.sv]
// Purpose: Walks the chain over a good link and over a broken one
// Assumes: Settle count shortened to 2 cycles
// Notes:   Broken link has its fifth chain input open

`timescale 1ns/1ps

module test_nand_tree_connectivity_test;
    import ntc_pkg::*;
    localparam int N = NTC_CHAIN_INPUTS;
    logic                 CLK     = 1'b0;
    logic                 RESET   = 1'b1;
    logic                 enable  = 1'b1;
    logic                 start   = 1'b0;
    logic                 int_req = 1'b0;
    logic                 test_mode, busy, done, pass, init_fail;
    logic                 level_error, level_error_f, pass_f, pin_q = 1'b1;
    logic [NTC_CNT_W-1:0] fault_count, fault_count_f;
    logic [NTC_IDX_W-1:0] step, first_fault_f;
    logic [N-1:0]         fault_map_f;
    int                   err_total = 0, comparisons = 0, toggles = 0;

    ntc_if #(.N(N)) link_i();
    ntc_if #(.N(N)) link_f_i();

    always #12.5 CLK = ~CLK;

    ntc_device_end #(.N(N)) ntc_device_end_i (.CLK(CLK), .RESET(RESET),
        .INT_REQ(int_req), .TEST_MODE(test_mode), .LINK(link_i.device));
    ntc_board_end #(.N(N), .SETTLE_CYCLES(2)) ntc_board_end_i (.CLK(CLK),
        .RESET(RESET), .ENABLE(enable), .START(start), .BUSY(busy),
        .DONE(done), .PASS(pass), .INIT_FAIL(init_fail),
        .LEVEL_ERROR(level_error), .FAULT_COUNT(fault_count),
        .FIRST_FAULT(), .FAULT_MAP(), .STEP(step), .LINK(link_i.board));
    ntc_board_end #(.N(N), .SETTLE_CYCLES(2)) ntc_board_end_f_i (.CLK(CLK),
        .RESET(RESET), .ENABLE(enable), .START(start), .BUSY(), .DONE(),
        .PASS(pass_f), .INIT_FAIL(), .LEVEL_ERROR(level_error_f),
        .FAULT_COUNT(fault_count_f), .FIRST_FAULT(first_fault_f),
        .FAULT_MAP(fault_map_f), .STEP(), .LINK(link_f_i.board));
    ntc_link_properties #(.N(N)) ntc_link_properties_i (.CLK(CLK),
        .RESET(RESET), .chain_in(link_i.chain_in),
        .test_strap_a(link_i.test_strap_a),
        .test_strap_b(link_i.test_strap_b),
        .test_strap_c(link_i.test_strap_c),
        .chain_result_out(link_i.chain_result_out),
        .chain_result_oe(link_i.chain_result_oe),
        .chain_result_pin(link_i.chain_result_pin));

    // Stand-in device: open fifth input reads high, others form the chain
    wire logic [N-1:0] seen = link_f_i.chain_in | (N'(1'h1) << 4);
    assign link_f_i.chain_result_oe = 1'b1;
    always @(posedge CLK) link_f_i.chain_result_out <= ~^(~seen);

    // Counted mid-cycle, where the registered result pin is settled
    always @(negedge CLK)
    begin
        pin_q <= link_i.chain_result_pin;
        if (busy === 1'b1 && pin_q !== link_i.chain_result_pin)
            toggles <= toggles + 1;
    end

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic run_walk();
        int n = 0;
        @(negedge CLK) start = 1'b1;
        @(negedge CLK) start = 1'b0;
        while (done !== 1'b1 && n < 1000)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        if (n >= 1000)
            err_total++;
    endtask : run_walk

    task automatic final_report();
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (5000) @(posedge CLK);
        err_total++;
        final_report();
    end

    initial
    begin
        repeat (20) @(negedge CLK);
        RESET = 1'b0;
        repeat (3) @(negedge CLK);
        check("test_mode", 64'h1, test_mode);
        run_walk();
        check("pass", 64'h1, pass);
        check("init_fail", 64'h0, init_fail);
        check("level_error", 64'h0, level_error);
        check("fault_count", 64'h0, fault_count);
        check("step", 64'h31, step);
        check("toggles", 64'h31, toggles);
        check("chain_in", 64'h0, link_i.chain_in);
        check("pin", 64'h0, link_i.chain_result_pin);
        check("fault_map_f", 64'h10, fault_map_f);
        check("first_fault_f", 64'h5, first_fault_f);
        check("fault_count_f", 64'h1, fault_count_f);
        check("pass_f", 64'h0, pass_f);
        check("level_error_f", 64'h1, level_error_f);
        @(negedge CLK) RESET = 1'b1;
        enable = 1'b0;
        int_req = 1'b1;
        repeat (2) @(negedge CLK);
        RESET = 1'b0;
        repeat (3) @(negedge CLK);
        check("test_mode", 64'h0, test_mode);
        check("pin", 64'h0, link_i.chain_result_pin);
        start = 1'b1;
        @(negedge CLK) start = 1'b0;
        int_req = 1'b0;
        repeat (2) @(negedge CLK);
        check("busy", 64'h0, busy);
        check("pin", 64'h1, link_i.chain_result_pin);
        final_report();
    end

endmodule : test_nand_tree_connectivity_test
